// ==== tdpwm_pkg.sv ====
package tdpwm_pkg;
    // ==========================================================
    // Control word layout
    localparam int MODE_LSB        = 0;
    localparam int MODE_W          = 2;
    localparam int CLKSEL_LSB      = 2;
    localparam int CLKSEL_W        = 3;
    localparam int RUN_BIT         = 5;
    localparam int CTRL_W          = 6;
    localparam logic [MODE_W-1:0] MODE_TIMER = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RSVD  = 2'h1;
    localparam logic [MODE_W-1:0] MODE_DIV   = 2'h2;
    localparam logic [MODE_W-1:0] MODE_PWM   = 2'h3;
    // ==========================================================
    // Reset values
    localparam logic [7:0]        CMP_RESET  = 8'hFF;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    // ==========================================================
    // Prescaler: source clock select code to divide exponent
    localparam int PRESC_W = 13;
    function automatic logic [3:0] tdpwm_div_exp(input logic [2:0] sel, input logic dv);
        logic [3:0] e;
        e = 4'h0;
        unique case (sel)
            3'h0: e = 4'hB;
            3'h1: e = 4'h7;
            3'h2: e = 4'h5;
            3'h3: e = 4'h3;
            3'h4: e = 4'h2;
            3'h5: e = 4'h1;
            3'h6: e = 4'h0;
            3'h7: e = 4'h0;
        endcase
        return (sel == 3'h7) ? 4'h0 : 4'((e + {3'h0, dv}));
    endfunction
    typedef enum logic [1:0] {TDPWM_IDLE, TDPWM_DIV, TDPWM_PWM} tdpwm_state_e;
endpackage : tdpwm_pkg

// ==== tdpwm_prescaler.sv ====
`timescale 1ns/100ps
`default_nettype none
// One-cycle tick every 2**exp system clocks
module tdpwm_prescaler #(
    parameter int W = tdpwm_pkg::PRESC_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clear_i,
    input  wire logic [3:0] exp_i,
    output logic            tick_o
);
    import tdpwm_pkg::*;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] mask;

    // ==========================================================
    // Free counter, held at zero while stopped so the first tick is a full period
    always_comb begin
        mask  = W'((32'h1 << exp_i) - 32'h1);
        cnt_d = clear_i ? '0 : W'(cnt_q + 1'b1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Tick when low bits wrap; exp of 0 ticks every clock
    assign tick_o = !clear_i && ((cnt_q & mask) == mask);
endmodule // tdpwm_prescaler
`default_nettype wire

// ==== tdpwm_timer.sv ====
// Contract
// - Divider mode gives 50 percent square wave from internal source clock.
// - Divider match: toggle pin, raise interrupt, clear counter, keep counting.
// - Divider pin is high while the timer is stopped.
// - Mode field value 10 selects divider output mode.
// - Counting starts when the control word is written with run bit set.
// - Modulation mode gives up to 8-bit resolution from internal clock.
// - Modulation match drives pin low; counter keeps running, not cleared.
// - Modulation overflow drives pin high and raises interrupt same cycle.
// - Modulation pin is high while the timer is stopped.
// - Compare buffered; in modulation mode new value reaches active stage after period ends, in divider mode at once.
// - First compare value moves to active stage when timer starts.
// - Rewrite compare after interrupt; coincident write at overflow loads the new value.
// - Entering stop state clears the run bit automatically.
`timescale 1ns/100ps
`default_nettype none
module tdpwm_timer
    import tdpwm_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RESETN_I,
    input  wire logic [tdpwm_pkg::CTRL_W-1:0] CTRL_WDATA_I,
    input  wire logic                         CTRL_WR_I,
    input  wire logic [CNT_W-1:0]             CMP_WDATA_I,
    input  wire logic                         CMP_WR_I,
    input  wire logic                         DIV_SEL_I,
    input  wire logic                         STOP_ENTRY_I,
    output logic [tdpwm_pkg::CTRL_W-1:0]      CTRL_RDATA_O,
    output logic [CNT_W-1:0]                  CMP_RDATA_O,
    output logic [CNT_W-1:0]                  COUNT_O,
    output logic                              DIV_OUT_O,
    output logic                              PWM_OUT_O,
    output logic                              MATCH_IRQ_O
);
    import tdpwm_pkg::*;

    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [CNT_W-1:0]  cmp_buf_q, cmp_buf_d;
    logic [CNT_W-1:0]  cmp_act_q, cmp_act_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              div_q, div_d;
    logic              pwm_q, pwm_d;
    logic              irq_q, irq_d;
    logic              run;
    logic              start;
    logic              tick;
    logic              match;
    logic              ovf;
    logic [MODE_W-1:0] mode;
    tdpwm_state_e      state;

    assign mode = ctrl_q[MODE_LSB +: MODE_W];
    assign run  = ctrl_q[RUN_BIT];
    // Rising edge of run bit through a control write
    assign start = CTRL_WR_I && CTRL_WDATA_I[RUN_BIT] && !run && !STOP_ENTRY_I;

    // ==========================================================
    // Active function; the timer and reserved modes drive no pin here
    always_comb begin
        state = TDPWM_IDLE;
        if (run && mode == MODE_DIV) begin
            state = TDPWM_DIV;
        end else if (run && mode == MODE_PWM) begin
            state = TDPWM_PWM;
        end
    end

    tdpwm_prescaler u_presc (
        .clk_i   (CLK_I),
        .rst_n_i (RESETN_I),
        .clear_i (!run),
        .exp_i   (tdpwm_div_exp(ctrl_q[CLKSEL_LSB +: CLKSEL_W], DIV_SEL_I)),
        .tick_o  (tick)
    );

    // ==========================================================
    // Control word and compare buffer
    always_comb begin
        ctrl_d    = ctrl_q;
        cmp_buf_d = cmp_buf_q;
        if (CTRL_WR_I) begin
            ctrl_d = CTRL_WDATA_I;
        end
        // Stop entry wins over a simultaneous start write
        if (STOP_ENTRY_I) begin
            ctrl_d[RUN_BIT] = 1'b0;
        end
        if (CMP_WR_I) begin
            cmp_buf_d = CMP_WDATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_q    <= CTRL_RESET;
            cmp_buf_q <= CMP_RESET;
        end else begin
            ctrl_q    <= ctrl_d;
            cmp_buf_q <= cmp_buf_d;
        end
    end

    // ==========================================================
    // Counter, pins, interrupt, active compare stage
    assign match = tick && (cnt_q == cmp_act_q);
    assign ovf   = tick && (cnt_q == {CNT_W{1'b1}});

    always_comb begin
        cnt_d     = cnt_q;
        cmp_act_d = cmp_act_q;
        div_d     = 1'b1;
        pwm_d     = 1'b1;
        irq_d     = 1'b0;
        if (start) begin
            // Start clears the counter and loads the first value
            cnt_d     = '0;
            cmp_act_d = CMP_WR_I ? CMP_WDATA_I : cmp_buf_q;
        end else begin
            unique case (state)
                TDPWM_IDLE: begin
                    cnt_d = '0;
                end
                TDPWM_DIV: begin
                    div_d = div_q;
                    // Divider reads the buffer directly: a write while running takes effect at once
                    cmp_act_d = cmp_buf_q;
                    if (tick && cnt_q == cmp_buf_q) begin
                        div_d = !div_q;
                        irq_d = 1'b1;
                        cnt_d = '0;
                    end else if (tick) begin
                        cnt_d = CNT_W'(cnt_q + 1'b1);
                    end
                end
                TDPWM_PWM: begin
                    pwm_d = pwm_q;
                    if (tick) begin
                        cnt_d = CNT_W'(cnt_q + 1'b1);
                    end
                    if (match) begin
                        pwm_d = 1'b0;
                    end
                    if (ovf) begin
                        pwm_d     = 1'b1;
                        irq_d     = 1'b1;
                        // Write in the same cycle is taken as is; software avoids it
                        cmp_act_d = CMP_WR_I ? CMP_WDATA_I : cmp_buf_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cnt_q     <= '0;
            cmp_act_q <= CMP_RESET;
            div_q     <= 1'b1;
            pwm_q     <= 1'b1;
            irq_q     <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            cmp_act_q <= cmp_act_d;
            div_q     <= div_d;
            pwm_q     <= pwm_d;
            irq_q     <= irq_d;
        end
    end

    assign CTRL_RDATA_O = ctrl_q;
    assign CMP_RDATA_O  = cmp_buf_q;
    assign COUNT_O      = cnt_q;
    assign DIV_OUT_O    = div_q;
    assign PWM_OUT_O    = pwm_q;
    assign MATCH_IRQ_O  = irq_q;

    // ==========================================================
    // Tick tally, read by the checks only
    // Counts source ticks since start, divider toggle or overflow.
    // Kept apart from the up-counter so that a wrong wrap or a
    // missed clear shows up as a length mismatch below.
    logic [CNT_W:0] span_q;
    logic [CNT_W:0] span_d;
    logic           span_end;

    // Half period ends in divider mode, full period otherwise
    assign span_end = (state == TDPWM_DIV) ? (tick && cnt_q == cmp_buf_q) : ovf;

    // Cleared on every boundary; idle parks it at zero
    always_comb begin
        span_d = span_q;
        if (start || state == TDPWM_IDLE || span_end) begin
            span_d = '0;
        end else if (tick) begin
            span_d = span_q + {{CNT_W{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            span_q <= '0;
        end else begin
            span_q <= span_d;
        end
    end

    // ==========================================================
    // Checks
    // All sampled on the system clock; a reset in progress masks them
    a_div_match_toggle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_DIV && !start && tick && cnt_q == cmp_buf_q)
        |=> (DIV_OUT_O != $past(DIV_OUT_O)) && MATCH_IRQ_O && COUNT_O == '0)
        else $error("divider match did not toggle, flag and clear");
    a_div_idle_high: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state != TDPWM_DIV) |=> DIV_OUT_O)
        else $error("divider pin low while not running in divider mode");
    a_pwm_idle_high: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state != TDPWM_PWM) |=> PWM_OUT_O)
        else $error("modulation pin low while not running");
    a_pwm_match_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && match && !ovf)
        |=> !PWM_OUT_O && COUNT_O == CNT_W'($past(cnt_q) + 1'b1))
        else $error("modulation match did not drive low");
    a_pwm_ovf_high: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && ovf) |=> PWM_OUT_O && MATCH_IRQ_O && COUNT_O == '0)
        else $error("overflow did not drive high with interrupt");
    a_pwm_cmp_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && !ovf) |=> $stable(cmp_act_q))
        else $error("active compare changed mid period");
    a_start_load: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (start && !CMP_WR_I) |=> cmp_act_q == $past(cmp_buf_q) && COUNT_O == '0)
        else $error("start did not load compare");
    a_stop_clears: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        STOP_ENTRY_I |=> !CTRL_RDATA_O[RUN_BIT])
        else $error("stop entry left run bit set");
    a_irq_cause: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        MATCH_IRQ_O |-> $past(tick) && $past(run))
        else $error("interrupt without source tick");

    // Divider: stepping between matches, even halves; mode decode of both functions
    a_div_count_step: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_DIV && !start && tick && cnt_q != cmp_buf_q)
        |=> COUNT_O == CNT_W'($past(cnt_q) + 1'b1) && !MATCH_IRQ_O
            && DIV_OUT_O == $past(DIV_OUT_O))
        else $error("divider counter did not step between matches");
    a_div_tick_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_DIV && !start && !tick) |=> $stable(cnt_q) && $stable(div_q))
        else $error("divider moved without a source tick");
    a_div_half_span: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_DIV && !start && span_end) |-> span_q == {1'b0, cmp_buf_q})
        else $error("divider half periods differ in length");
    a_div_mode_code: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (run && ctrl_q[MODE_LSB +: MODE_W] == 2'h2) |-> state == TDPWM_DIV)
        else $error("mode code 10 did not select the divider");
    a_pwm_mode_code: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (run && ctrl_q[MODE_LSB +: MODE_W] == 2'h3) |-> state == TDPWM_PWM)
        else $error("mode code 11 did not select modulation");

    // Modulation: stepping, quiet cycles, period length, shift stage
    // A write landing on the overflow cycle is taken as it stands
    a_pwm_count_step: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && tick) |=> COUNT_O == CNT_W'($past(cnt_q) + 1'b1))
        else $error("modulation counter did not step on a tick");
    a_pwm_pin_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && !match && !ovf)
        |=> PWM_OUT_O == $past(PWM_OUT_O) && !MATCH_IRQ_O)
        else $error("modulation pin or interrupt moved without an event");
    a_pwm_full_span: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && ovf) |-> span_q == {1'b0, {CNT_W{1'b1}}})
        else $error("modulation period is not the full counter span");
    a_pwm_ovf_load: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && ovf && !CMP_WR_I) |=> cmp_act_q == $past(cmp_buf_q))
        else $error("buffered compare not shifted at period end");
    a_pwm_late_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_PWM && !start && ovf && CMP_WR_I) |=> cmp_act_q == $past(CMP_WDATA_I))
        else $error("compare written at overflow not taken");

    // Control and compare writes, start and stop entry
    a_start_runs: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        start |=> CTRL_RDATA_O[RUN_BIT] && COUNT_O == '0)
        else $error("start write did not set run with a clear counter");
    a_ctrl_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (CTRL_WR_I && !STOP_ENTRY_I) |=> CTRL_RDATA_O == $past(CTRL_WDATA_I))
        else $error("control write did not land");
    a_start_with_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (start && CMP_WR_I) |=> cmp_act_q == $past(CMP_WDATA_I))
        else $error("start ignored the compare written with it");
    a_cmp_buf_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        CMP_WR_I |=> CMP_RDATA_O == $past(CMP_WDATA_I))
        else $error("compare write did not reach the buffer");
    a_stop_pins_high: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        STOP_ENTRY_I |=> ##1 (DIV_OUT_O && PWM_OUT_O))
        else $error("pins not released high after stop entry");

    // Idle: counter parked at zero, no interrupt
    a_idle_quiet: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == TDPWM_IDLE && !start) |=> COUNT_O == '0 && !MATCH_IRQ_O)
        else $error("counter or interrupt active while idle");
endmodule // tdpwm_timer
`default_nettype wire

// ==== tdpwm_pin_probe.sv ====
`timescale 1ns/100ps
`default_nettype none
// Receiving circuit: measures the last high and low run of a pin, in clocks
module tdpwm_pin_probe (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        pin_i,
    output logic      [15:0] hi_len_o,
    output logic      [15:0] lo_len_o
);
    logic [15:0] run_q;
    logic        last_q;
    // A run closes on the first sample of the opposite level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q    <= 16'h0001;
            last_q   <= 1'b1;
            hi_len_o <= 16'h0000;
            lo_len_o <= 16'h0000;
        end else if (pin_i === last_q) begin
            run_q <= run_q + 16'h0001;
        end else begin
            if (last_q) hi_len_o <= run_q;
            else lo_len_o <= run_q;
            run_q  <= 16'h0001;
            last_q <= pin_i;
        end
    end
endmodule // tdpwm_pin_probe
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tdpwm_pkg::*;
    logic              clk        = 1'b0;
    logic              resetn     = 1'b0;
    logic [CTRL_W-1:0] ctrl_wdata = 6'h00;
    logic              ctrl_wr    = 1'b0;
    logic [7:0]        cmp_wdata  = 8'h00;
    logic              cmp_wr     = 1'b0;
    logic              div_sel    = 1'b0;
    logic              stop_entry = 1'b0;
    logic [CTRL_W-1:0] ctrl_rdata;
    logic [7:0]        cmp_rdata, count;
    logic              div_out, pwm_out, match_irq;
    logic [15:0]       div_hi, div_lo, pwm_hi, pwm_lo;
    int                err_total       = 0;
    int                samples_checked = 0;
    int                irq_cnt         = 0;
    int                n;
    // ==========================================================
    // Clock, interrupt tally, design and pin receivers
    always #50 clk = ~clk;
    always @(posedge clk) if (match_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    tdpwm_timer i_dut (.CLK_I(clk), .RESETN_I(resetn), .CTRL_WDATA_I(ctrl_wdata),
        .CTRL_WR_I(ctrl_wr), .CMP_WDATA_I(cmp_wdata), .CMP_WR_I(cmp_wr),
        .DIV_SEL_I(div_sel), .STOP_ENTRY_I(stop_entry), .CTRL_RDATA_O(ctrl_rdata),
        .CMP_RDATA_O(cmp_rdata), .COUNT_O(count), .DIV_OUT_O(div_out),
        .PWM_OUT_O(pwm_out), .MATCH_IRQ_O(match_irq));
    tdpwm_pin_probe i_div_rx (.clk_i(clk), .rst_n_i(resetn), .pin_i(div_out),
        .hi_len_o(div_hi), .lo_len_o(div_lo));
    tdpwm_pin_probe i_pwm_rx (.clk_i(clk), .rst_n_i(resetn), .pin_i(pwm_out),
        .hi_len_o(pwm_hi), .lo_len_o(pwm_lo));
    // ==========================================================
    // Access and compare tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_ctrl(input logic [5:0] v);
        @(posedge clk);
        ctrl_wdata <= v;
        ctrl_wr    <= 1'b1;
        @(posedge clk);
        ctrl_wr <= 1'b0;
    endtask
    task automatic wr_cmp(input logic [7:0] v);
        @(posedge clk);
        cmp_wdata <= v;
        cmp_wr    <= 1'b1;
        @(posedge clk);
        cmp_wr <= 1'b0;
    endtask
    // Looks just after the edge so registered outputs have landed
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Bounded wait; n ends as the number of clocks waited
    task automatic wait_irq;
        n = 0;
        do begin
            idle(1);
            n++;
        end while (match_irq !== 1'b1 && n < 2000);
        if (n >= 2000) err_total++;
    endtask
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Watchdog: whole run needs under 8000 clocks
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        idle(0);
        chk(ctrl_rdata, CTRL_RESET);
        chk(cmp_rdata, CMP_RESET);
        chk(count, 8'h00);
        chk({div_out, pwm_out, match_irq}, 3'b110);
        // Divider, one tick per clock: half period is compare plus one
        wr_cmp(8'h02);
        wr_ctrl(6'h3A);
        idle(30);
        chk(div_hi, 16'h0003);
        chk(div_lo, 16'h0003);
        n = irq_cnt;
        idle(60);
        chk(irq_cnt - n, 16'h0014);
        chk(pwm_out, 1'b1);
        // Stop in a low phase; run clears in its last clock, so no truncation is seen
        n = 0;
        while (div_out !== 1'b0 && n < 10) begin
            idle(1);
            n++;
        end
        wr_ctrl(6'h1A);
        idle(2);
        chk(div_out, 1'b1);
        // Divider through the prescaler: divide by four
        @(posedge clk);
        div_sel <= 1'b1;
        wr_cmp(8'h01);
        wr_ctrl(6'h36);
        idle(80);
        chk(div_hi, 16'h0008);
        chk(div_lo, 16'h0008);
        wr_ctrl(6'h16);
        // Modulation: first compare is taken at start
        @(posedge clk);
        div_sel <= 1'b0;
        wr_cmp(8'h40);
        wr_ctrl(6'h3B);
        wait_irq();
        wait_irq();
        chk(n, 16'h0100);
        chk({pwm_out, count}, 9'h100);
        chk(div_out, 1'b1);
        // Write mid-period; it must wait for the overflow
        idle(16'h0030);
        wr_cmp(8'h80);
        wait_irq();
        idle(2);
        chk(pwm_hi, 16'h0041);
        chk(pwm_lo, 16'h00BF);
        idle(16'h0090);
        chk(pwm_hi, 16'h0081);
        // Stop-state entry during the low phase
        idle(16'h0010);
        chk(pwm_out, 1'b0);
        @(posedge clk);
        stop_entry <= 1'b1;
        @(posedge clk);
        stop_entry <= 1'b0;
        idle(2);
        chk(ctrl_rdata, 6'h1B);
        chk(pwm_out, 1'b1);
        // Modulation through the prescaler: one tick every four clocks
        wr_ctrl(6'h13);
        wr_ctrl(6'h33);
        wait_irq();
        wait_irq();
        chk(n, 16'h0400);
        chk(pwm_hi, 16'h0204);
        wr_ctrl(6'h13);
        // Timer and reserved modes must leave both pins and irq alone
        for (int m = 0; m < 2; m++) begin
            wr_ctrl(6'h18 | 6'(m));
            wr_ctrl(6'h38 | 6'(m));
            n = irq_cnt;
            idle(300);
            chk(irq_cnt - n, 16'h0000);
            chk({div_out, pwm_out}, 2'b11);
            chk(count, 8'h00);
        end
        test_done();
    end
endmodule // testbench
`default_nettype wire
